// ==== design/airc_top.sv ====
// input multiplexer, reference and master clock selection around a converter
// assumes a classic wishbone master on clk and analog switches driven by the
// select outputs
//
// Contract
// - Up to eight channels; enabled ones convert lowest to highest, then repeat.
// - Any of nine inputs may feed either side of a channel pair.
// - Input buffers can be bypassed, mux feeding the sampler directly.
// - Setup bits 5..4 choose primary, second reference pair or supply span.
// - After power-up the reference is the primary external pair.
// - Modulator runs from a nominal 2 MHz master clock from the chosen source.
// - Mode bits 3..2 choose internal oscillator, crystal or external clock.
// - Power-up and reset select the internal oscillator.
// - Internal 16 MHz oscillator is divided down to 2 MHz.
// - A 16 MHz crystal is divided automatically to 2 MHz.
// - All rates scale with master clock frequency.
// - Option drives the internal oscillator out on the crystal/clock pin.
// - External clock enters on the crystal/clock pin and drives the modulator.
// - Channel register top bit enables the channel in the sequence.
//
// Our own choice: the Wishbone register port.
`timescale 1ns/10ps
module airc_top
  import airc_pkg::*;
#(
  parameter int unsigned CONV_TICKS = 64
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // crystal and clock pins
  input  wire logic        crystal_in,
  input  wire logic        crystal_clock_io_pin_i,
  output logic             crystal_clock_io_pin_o,
  output logic             crystal_clock_io_pin_oe,
  // analog selection
  output logic [3:0]       ain_pos_sel,
  output logic [3:0]       ain_neg_sel,
  output logic [1:0]       ain_buf_en,
  output logic [1:0]       reference_source_field,
  output logic [1:0]       master_clock_source_field,
  // converter timing
  output logic             mclk_tick,
  output logic             conv_done,
  output logic [2:0]       active_chan
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0]             mode;
    logic [15:0]             setup0;
    logic [N_CHAN-1:0][15:0] chan;
    logic                    clkout;
    logic [31:0]             rdat;
    logic                    ack;
    logic [3:0]              pos;
    logic [3:0]              neg;
    logic [1:0]              buf_en;
    logic [1:0]              refsel;
    logic [1:0]              clksel;
    logic                    pin_o;
    logic                    pin_oe;
    logic                    tick;
    logic                    done;
    logic [2:0]              act;
  } airc_top_st_t;

  airc_top_st_t st_ff, nxt_st;

  logic              osc_edge;
  logic              div_tick;
  logic [2:0]        seq_chan;
  logic              seq_busy;
  logic              seq_done;
  logic [N_CHAN-1:0] chan_en;
  logic [1:0]        clk_src;

  // ---------------------------------------------------------------
  // field decoding
  // ---------------------------------------------------------------
  // reserved clock code is internal
  function automatic logic [1:0] dec_clk(input logic [15:0] mode);
    logic [1:0] f;
    f = mode[CLKSEL_LSB +: 2];
    if (f == CLK_CRYSTAL || f == CLK_EXTERNAL) begin
      return f;
    end
    return CLK_INTERNAL;
  endfunction : dec_clk

  function automatic logic [1:0] dec_ref(input logic [15:0] setup);
    logic [1:0] f;
    f = setup[REFSEL_LSB +: 2];
    if (f == REF_SECOND || f == REF_SUPPLY) begin
      return f;
    end
    return REF_PRIMARY;
  endfunction : dec_ref

  // merge byte lanes 0 and 1 into a 16-bit register
  function automatic logic [15:0] lane_wr(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      r[15:8] = dat[15:8];
    end
    return r;
  endfunction : lane_wr

  // top bit of each channel register
  generate
    for (genvar g = 0; g < N_CHAN; g++) begin : g_en
      assign chan_en[g] = st_ff.chan[g][CHEN_BIT];
    end
  endgenerate

  assign clk_src = dec_clk(st_ff.mode);

  // ---------------------------------------------------------------
  // clock and sequencer
  // ---------------------------------------------------------------
  airc_clk_div u_div (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .src_sel   (clk_src),
    .xtal_pin  (crystal_in),
    .clkio_pin (crystal_clock_io_pin_i),
    .osc_edge  (osc_edge),
    .mclk_tick (div_tick)
  );

  airc_chan_seq #(
    .CONV_TICKS (CONV_TICKS)
  ) u_seq (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .chan_en   (chan_en),
    .mclk_tick (div_tick),
    .cur_chan  (seq_chan),
    .busy      (seq_busy),
    .conv_done (seq_done)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [5:0]  idx;
    logic        req;
    logic [15:0] rd;
    idx    = wb_adr_i[7:2];
    req    = wb_cyc_i & wb_stb_i & ~st_ff.ack;
    rd     = 16'h0000;
    nxt_st = st_ff;

    // single-wait answer; unmapped reads zero, writes dropped
    nxt_st.ack = req;
    if (idx == IDX_MODE) begin
      rd = st_ff.mode;
    end else if (idx == IDX_SETUP0) begin
      rd = st_ff.setup0;
    end else if (idx == IDX_CLKOUT) begin
      rd = {15'h0000, st_ff.clkout};
    end else if (idx == IDX_STATUS) begin
      rd = {8'h00, seq_busy, st_ff.act, 2'h0, st_ff.clksel};
    end else if (idx >= IDX_CHAN0 && idx < IDX_CHAN0 + 6'(N_CHAN)) begin
      rd = st_ff.chan[3'(idx - IDX_CHAN0)];
    end
    nxt_st.rdat = req ? {16'h0000, rd} : st_ff.rdat;

    if (req && wb_we_i) begin
      if (idx == IDX_MODE) begin
        nxt_st.mode = lane_wr(st_ff.mode, wb_dat_i, wb_sel_i);
      end else if (idx == IDX_SETUP0) begin
        nxt_st.setup0 = lane_wr(st_ff.setup0, wb_dat_i, wb_sel_i);
      end else if (idx == IDX_CLKOUT && wb_sel_i[0]) begin
        nxt_st.clkout = wb_dat_i[CLKOUT_BIT];
      end else if (idx >= IDX_CHAN0 && idx < IDX_CHAN0 + 6'(N_CHAN)) begin
        nxt_st.chan[3'(idx - IDX_CHAN0)] =
          lane_wr(st_ff.chan[3'(idx - IDX_CHAN0)], wb_dat_i, wb_sel_i);
      end
    end

    // any input on either side of the pair
    nxt_st.pos    = st_ff.chan[seq_chan][AINPOS_LSB +: 4];
    nxt_st.neg    = st_ff.chan[seq_chan][AINNEG_LSB +: 4];
    nxt_st.buf_en = st_ff.setup0[AINBUF_LSB +: 2];
    nxt_st.refsel = dec_ref(st_ff.setup0);
    nxt_st.clksel = clk_src;
    nxt_st.tick   = div_tick;
    nxt_st.done   = seq_done;
    nxt_st.act    = seq_chan;

    // oscillator out, 8 MHz square; only while internal source runs
    nxt_st.pin_oe = st_ff.clkout & (clk_src == CLK_INTERNAL);
    if (osc_edge) begin
      nxt_st.pin_o = ~st_ff.pin_o;
    end
    // pin is input when external clock or crystal is used
    if (!nxt_st.pin_oe) begin
      nxt_st.pin_o = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.mode   <= RST_MODE;
      st_ff.setup0 <= RST_SETUP0;
      st_ff.chan   <= {{(N_CHAN - 1){RST_CHAN}}, RST_CHAN0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign wb_dat_o                  = st_ff.rdat;
  assign wb_ack_o                  = st_ff.ack;
  assign crystal_clock_io_pin_o    = st_ff.pin_o;
  assign crystal_clock_io_pin_oe   = st_ff.pin_oe;
  assign ain_pos_sel               = st_ff.pos;
  assign ain_neg_sel               = st_ff.neg;
  assign ain_buf_en                = st_ff.buf_en;
  assign reference_source_field    = st_ff.refsel;
  assign master_clock_source_field = st_ff.clksel;
  assign mclk_tick                 = st_ff.tick;
  assign conv_done                 = st_ff.done;
  assign active_chan               = st_ff.act;

endmodule : airc_top

// ==== design/airc_pkg.sv ====
// shared constants for the converter input, reference and clock selection block
// assumes a 200 MHz system clock and a classic wishbone register port
package airc_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ  = 200_000_000;
  localparam int unsigned OSC_HZ      = 16_000_000;
  localparam int unsigned MCLK_HZ     = 2_000_000;
  // master clock is the internal or crystal source divided by this; the external clock is not divided
  localparam int unsigned SRC_DIV     = OSC_HZ / MCLK_HZ;
  // phase accumulator modulus for the internal oscillator model
  localparam int unsigned OSC_ACC_MOD = SYS_CLK_HZ / 1_000_000;
  localparam int unsigned OSC_ACC_INC = OSC_HZ / 1_000_000;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_MODE    = 6'h01;
  localparam logic [5:0] IDX_CLKOUT  = 6'h06;
  localparam logic [5:0] IDX_STATUS  = 6'h07;
  localparam logic [5:0] IDX_CHAN0   = 6'h10;
  localparam logic [5:0] IDX_SETUP0  = 6'h20;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_MODE   = 16'h2000;
  localparam logic [15:0] RST_SETUP0 = 16'h1000;
  localparam logic [15:0] RST_CHAN   = 16'h0000;
  localparam logic [15:0] RST_CHAN0  = 16'h8001;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned CLKSEL_LSB  = 2;
  localparam int unsigned REFSEL_LSB  = 4;
  localparam int unsigned CHEN_BIT    = 15;
  localparam int unsigned AINPOS_LSB  = 4;
  localparam int unsigned AINNEG_LSB  = 0;
  localparam int unsigned AINBUF_LSB  = 8;
  localparam int unsigned CLKOUT_BIT  = 0;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned N_CHAN      = 8;
  localparam int unsigned N_AIN       = 9;

  // ---------------------------------------------------------------
  // field codes
  // ---------------------------------------------------------------
  localparam logic [1:0] REF_PRIMARY  = 2'h0;
  localparam logic [1:0] REF_SECOND   = 2'h1;
  localparam logic [1:0] REF_SUPPLY   = 2'h2;
  localparam logic [1:0] CLK_INTERNAL = 2'h0;
  localparam logic [1:0] CLK_CRYSTAL  = 2'h1;
  localparam logic [1:0] CLK_EXTERNAL = 2'h2;

endpackage : airc_pkg

// ==== design/airc_clk_div.sv ====
// master clock generator: picks one of three sources and yields a 2 MHz tick
// assumes pin inputs are asynchronous to clk and at most a quarter of its rate
`timescale 1ns/10ps
module airc_clk_div
  import airc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // source select, already decoded
  input  wire logic [1:0] src_sel,
  // asynchronous pins
  input  wire logic       xtal_pin,
  input  wire logic       clkio_pin,
  // outputs
  output logic            osc_edge,
  output logic            mclk_tick
);

  typedef struct packed {
    logic [1:0] xs;
    logic [1:0] cs;
    logic       xd;
    logic       cd;
    logic [7:0] acc;
    logic [2:0] div;
    logic       osc;
    logic       tick;
  } airc_div_st_t;

  airc_div_st_t st_ff, nxt_st;

  always_comb begin
    logic osc_now;
    logic src_edge;
    osc_now  = 1'b0;
    src_edge = 1'b0;
    nxt_st   = st_ff;
    nxt_st.xs = {st_ff.xs[0], xtal_pin};
    nxt_st.cs = {st_ff.cs[0], clkio_pin};
    nxt_st.xd = st_ff.xs[1];
    nxt_st.cd = st_ff.cs[1];
    if (st_ff.acc + 8'(OSC_ACC_INC) >= 8'(OSC_ACC_MOD)) begin
      nxt_st.acc = st_ff.acc + 8'(OSC_ACC_INC) - 8'(OSC_ACC_MOD);
      osc_now    = 1'b1;
    end else begin
      nxt_st.acc = st_ff.acc + 8'(OSC_ACC_INC);
    end
    nxt_st.osc = osc_now;
    nxt_st.tick = 1'b0;
    unique case (src_sel)
      CLK_CRYSTAL:  src_edge = st_ff.xs[1] & ~st_ff.xd;
      CLK_EXTERNAL: src_edge = st_ff.cs[1] & ~st_ff.cd;
      default:      src_edge = osc_now;
    endcase
    if (src_sel == CLK_EXTERNAL) begin
      nxt_st.tick = src_edge;
      nxt_st.div  = 3'h0;
    end else if (src_edge) begin
      nxt_st.div = st_ff.div + 3'h1;
      nxt_st.tick = (st_ff.div == 3'(SRC_DIV - 1));
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign osc_edge  = st_ff.osc;
  assign mclk_tick = st_ff.tick;

endmodule : airc_clk_div

// ==== design/airc_chan_seq.sv ====
// channel sequencer: walks the enabled channels in ascending order, wrapping
// assumes one conversion spans a fixed number of master clock ticks
`timescale 1ns/10ps
module airc_chan_seq
  import airc_pkg::*;
#(
  parameter int unsigned CONV_TICKS = 64
)(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // control
  input  wire logic [N_CHAN-1:0] chan_en,
  input  wire logic              mclk_tick,
  // state
  output logic [2:0]             cur_chan,
  output logic                   busy,
  output logic                   conv_done
);

  typedef struct packed {
    logic [2:0]  chan;
    logic [15:0] cnt;
    logic        busy;
    logic        done;
  } airc_seq_st_t;

  airc_seq_st_t st_ff, nxt_st;

  // first enabled channel after cur, wrapping; cur itself comes last
  function automatic logic [2:0] next_chan(input logic [N_CHAN-1:0] en,
                                           input logic [2:0] cur);
    logic [2:0] res;
    logic       hit;
    res = cur;
    hit = 1'b0;
    for (int i = 1; i <= N_CHAN; i++) begin
      if (!hit && en[3'(cur + 3'(i))]) begin
        res = 3'(cur + 3'(i));
        hit = 1'b1;
      end
    end
    return res;
  endfunction : next_chan

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    if (chan_en == '0) begin
      nxt_st.busy = 1'b0;
      nxt_st.cnt  = '0;
    end else if (!st_ff.busy || !chan_en[st_ff.chan]) begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt  = '0;
      nxt_st.chan = next_chan(chan_en, 3'(N_CHAN - 1));
    end else if (mclk_tick) begin
      if (st_ff.cnt == 16'(CONV_TICKS - 1)) begin
        nxt_st.cnt  = '0;
        nxt_st.done = 1'b1;
        nxt_st.chan = next_chan(chan_en, st_ff.chan);
      end else begin
        nxt_st.cnt = st_ff.cnt + 16'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cur_chan  = st_ff.chan;
  assign busy      = st_ff.busy;
  assign conv_done = st_ff.done;

endmodule : airc_chan_seq

// ==== testbench/airc_asserts.sv ====
// checker for airc_top: bus answer, select decode, master tick timing
// assumes it is bound to airc_top and sees only that module's ports
`timescale 1ns/10ps
module airc_asserts
  import airc_pkg::*;
#(
  parameter int unsigned CONV_TICKS = 64
)(
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // bus
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // pin and selects
  input wire logic       crystal_clock_io_pin_o,
  input wire logic       crystal_clock_io_pin_oe,
  input wire logic [1:0] reference_source_field,
  input wire logic [1:0] master_clock_source_field,
  // timing
  input wire logic       mclk_tick,
  input wire logic       conv_done
);
  typedef struct packed {
    logic [7:0] gap;
    logic       ok;
    logic [1:0] src;
  } airc_gap_t;
  airc_gap_t gap_ff;
  airc_gap_t nxt_gap;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ----------------------------------------
  // tick spacing helper
  // ----------------------------------------
  always_comb begin
    nxt_gap = gap_ff;
    nxt_gap.src = master_clock_source_field;
    nxt_gap.gap = mclk_tick ? 8'h00 : gap_ff.gap + {7'h00, gap_ff.gap != 8'hff};
    // first interval after a source change has an arbitrary phase
    if (master_clock_source_field != gap_ff.src) begin
      nxt_gap.ok = 1'b0;
    end else if (mclk_tick) begin
      nxt_gap.ok = 1'b1;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_ff <= '0;
    end else begin
      gap_ff <= nxt_gap;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // reset defaults
  chk_rst_defaults:
    assert property ($past(sys_rst) |-> reference_source_field == REF_PRIMARY
      && master_clock_source_field == CLK_INTERNAL) else $error("selects not default");
  chk_ref_legal:
    assert property (reference_source_field != 2'h3) else $error("reserved ref shown");
  chk_src_legal:
    assert property (master_clock_source_field != 2'h3) else $error("reserved src shown");
  chk_tick_pulse:
    assert property (mclk_tick |=> !mclk_tick) else $error("tick too long");
  chk_tick_gap:
    assert property (mclk_tick && gap_ff.ok && master_clock_source_field == CLK_INTERNAL
      |-> gap_ff.gap == 8'h63) else $error("internal tick spacing wrong");
  chk_oe_source:
    assert property ($rose(crystal_clock_io_pin_oe)
      |-> master_clock_source_field == CLK_INTERNAL) else $error("pin driven off source");
  chk_pin_idle:
    assert property (!crystal_clock_io_pin_oe |-> !crystal_clock_io_pin_o)
      else $error("pin output while released");
  chk_ack_next:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  chk_done_tick:
    assert property (conv_done |-> $past(mclk_tick) || $past(mclk_tick, 2))
      else $error("conversion end without tick");

  cov_ack: cover property (wb_ack_o);
  cov_done: cover property (conv_done);
  cov_oe: cover property ($rose(crystal_clock_io_pin_oe));
endmodule : airc_asserts

bind airc_top airc_asserts #(.CONV_TICKS(CONV_TICKS)) u_airc_asserts (
  .clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .crystal_clock_io_pin_o,
  .crystal_clock_io_pin_oe, .reference_source_field, .master_clock_source_field,
  .mclk_tick, .conv_done);

// ==== testbench/airc_clk_src.sv ====
// far-side clock sources: a 16 MHz crystal and an external clock
// assumes the bench merges the external clock with the pin's own drive
`timescale 1ns/10ps
module airc_clk_src (
  // control
  input  wire logic        xtal_run,
  input  wire logic        ext_run,
  input  wire logic [15:0] ext_half_ns,
  // clock lines
  output logic             xtal_clk,
  output logic             ext_clk
);
  // lines stand low between runs; offset keeps edges off the system edge
  initial begin
    xtal_clk = 1'b0;
    forever begin
      wait (xtal_run);
      #1.3;
      while (xtal_run) begin
        xtal_clk = 1'b1;
        #31.25;
        xtal_clk = 1'b0;
        #31.25;
      end
    end
  end
  initial begin
    ext_clk = 1'b0;
    forever begin
      wait (ext_run);
      #1.3;
      while (ext_run) begin
        ext_clk = 1'b1;
        #(ext_half_ns);
        ext_clk = 1'b0;
        #(ext_half_ns);
      end
    end
  end
endmodule : airc_clk_src

// ==== testbench/adc_input_ref_clock_select_tb.sv ====
// bench for airc_top: register table, sources, tick rates, channel scan
// assumes airc_clk_src stands for the crystal and external clock
`timescale 1ns/10ps
module adc_input_ref_clock_select_tb
  import airc_pkg::*;
;
  typedef struct packed {
    logic [7:0]  a;
    logic [15:0] d;
    logic [15:0] r;
    logic [5:0]  f;
  } airc_row_t;
  logic        clk, sys_rst, cyc, stb, we, ack, pin_o, pin_oe;
  logic        xtal, ext, xtal_run, ext_run, tick, done, p;
  logic [7:0]  adr;
  logic [3:0]  sel, pos, neg;
  logic [31:0] wdat, rdat, q;
  logic [15:0] ext_half;
  logic [1:0]  buf_en, ref_f, src_f;
  logic [2:0]  chan, prev;
  logic [10:0] e;
  int          fail_count, checks_done, g, t;
  airc_row_t   rows [10] = '{
    '{8'h80, 16'h0010, 16'h0010, 6'h04}, '{8'h80, 16'h0020, 16'h0020, 6'h08},
    '{8'h80, 16'h0030, 16'h0030, 6'h00}, '{8'h80, 16'h0300, 16'h0300, 6'h30},
    '{8'h80, 16'h1000, 16'h1000, 6'h00}, '{8'h04, 16'h2004, 16'h2004, 6'h01},
    '{8'h04, 16'h2008, 16'h2008, 6'h02}, '{8'h04, 16'h200c, 16'h200c, 6'h00},
    '{8'h04, 16'h2000, 16'h2000, 6'h00}, '{8'h88, 16'h5555, 16'h0000, 6'h00}};

  airc_top #(.CONV_TICKS(4)) u_airc_top (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .crystal_in(xtal),
    .crystal_clock_io_pin_i(pin_oe ? pin_o : ext), .crystal_clock_io_pin_o(pin_o),
    .crystal_clock_io_pin_oe(pin_oe), .ain_pos_sel(pos), .ain_neg_sel(neg),
    .ain_buf_en(buf_en), .reference_source_field(ref_f), .master_clock_source_field(src_f),
    .mclk_tick(tick), .conv_done(done), .active_chan(chan));
  airc_clk_src u_airc_clk_src (.xtal_run(xtal_run), .ext_run(ext_run),
    .ext_half_ns(ext_half), .xtal_clk(xtal), .ext_clk(ext));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task wb(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (n >= 100) fail_count++;
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // skips to a tick, then counts cycles to the next one
  task tick_gap(output int c);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tick !== 1'b1 && n < 3000);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (tick !== 1'b1 && c < 3000);
  endtask : tick_gap

  task do_reset();
    // drive only on the rising edge, as the bus task does
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
  endtask : do_reset

  function automatic logic [10:0] scan_exp(input logic [2:0] c);
    case (c)
      3'h2: scan_exp = {3'h5, 4'h8, 4'h0};
      3'h5: scan_exp = {3'h7, 4'h3, 4'h4};
      default: scan_exp = {3'h2, 4'h0, 4'h8};
    endcase
  endfunction : scan_exp

  task finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    finish_test();
  end

  initial begin
    {sys_rst, cyc, stb, we, adr, sel, wdat} = {4'h8, 44'h0};
    {xtal_run, ext_run, ext_half, fail_count, checks_done} = {2'h0, 16'd250, 64'h0};
    do_reset();
    foreach (rows[i]) begin
      wb(1'b1, rows[i].a, rows[i].d, q);
      wb(1'b0, rows[i].a, 16'h0000, q);
      repeat (2) @(negedge clk);
      cmp(q, {16'h0000, rows[i].r});
      cmp({26'h0, buf_en, ref_f, src_f}, {26'h0, rows[i].f});
    end
    tick_gap(g);
    cmp(g, 32'h64);
    wb(1'b1, 8'h18, 16'h0001, q);
    repeat (3) @(negedge clk);
    t = 0;
    p = pin_o;
    repeat (100) begin
      @(negedge clk);
      if (pin_o !== p) t++;
      p = pin_o;
    end
    cmp({31'h0, pin_oe}, 32'h1);
    cmp(t, 32'h8);
    // crystal settles before the host goes on
    @(posedge clk);
    xtal_run <= 1'b1;
    repeat (200) @(posedge clk);
    wb(1'b1, 8'h04, 16'h2004, q);
    tick_gap(g);
    cmp(g, 32'h64);
    cmp({31'h0, pin_oe}, 32'h0);
    wb(1'b1, 8'h18, 16'h0000, q);
    ext_run <= 1'b1;
    wb(1'b1, 8'h04, 16'h2008, q);
    tick_gap(g);
    cmp(g, 32'h64);
    ext_half <= 16'd500;
    tick_gap(g);
    tick_gap(g);
    cmp(g, 32'hc8);
    ext_run <= 1'b0;
    wb(1'b1, 8'h04, 16'h2000, q);
    wb(1'b1, 8'h48, 16'h8080, q);
    wb(1'b1, 8'h54, 16'h8034, q);
    wb(1'b1, 8'h5c, 16'h8008, q);
    wb(1'b1, 8'h40, 16'h0001, q);
    prev = 3'h0;
    for (int i = 0; i < 6; i++) begin
      g = 0;
      do begin
        @(negedge clk);
        g++;
      end while (done !== 1'b1 && g < 2000);
      if (g >= 2000) fail_count++;
      repeat (2) @(negedge clk);
      e = scan_exp(prev);
      if (i > 0) cmp({29'h0, chan}, {29'h0, e[10:8]});
      e = scan_exp(chan);
      cmp({24'h0, pos, neg}, {24'h0, e[7:0]});
      prev = chan;
    end
    do_reset();
    wb(1'b0, 8'h04, 16'h0000, q);
    cmp(q, 32'h2000);
    wb(1'b0, 8'h80, 16'h0000, q);
    cmp(q, 32'h1000);
    wb(1'b0, 8'h40, 16'h0000, q);
    cmp(q, 32'h8001);
    cmp({28'h0, ref_f, src_f}, 32'h0);
    finish_test();
  end
endmodule : adc_input_ref_clock_select_tb
